// file: rtl/tec_pkg.sv
package tec_pkg;
  // Byte addresses of the registers
  localparam logic [11:0] TEC_OFF_CONTROL = 12'h088;
  localparam logic [11:0] TEC_OFF_MODE    = 12'h08c;
  localparam logic [11:0] TEC_OFF_COUNT0  = 12'h090;
  localparam logic [11:0] TEC_OFF_COUNT1  = 12'h094;
  localparam logic [11:0] TEC_OFF_STATUS  = 12'h098;
  localparam logic [11:0] TEC_OFF_MASK    = 12'h09c;

  // Control register bit positions
  localparam int TEC_BIT_T1_FLAG  = 7;
  localparam int TEC_BIT_T1_RUN   = 6;
  localparam int TEC_BIT_T0_FLAG  = 5;
  localparam int TEC_BIT_T0_RUN   = 4;
  localparam int TEC_BIT_X1_FLAG  = 3;
  localparam int TEC_BIT_X1_EDGE  = 2;
  localparam int TEC_BIT_X0_FLAG  = 1;
  localparam int TEC_BIT_X0_EDGE  = 0;

  // Mode register field positions
  localparam int TEC_MODE0_LSB = 0;
  localparam int TEC_MODE1_LSB = 4;

  // Event bits of status and mask
  localparam int TEC_EV_T0  = 0;
  localparam int TEC_EV_T1  = 1;
  localparam int TEC_EV_X0  = 2;
  localparam int TEC_EV_X1  = 3;
  localparam int TEC_EV_NUM = 4;

  // Reset values
  localparam logic [7:0]  TEC_CONTROL_RST = 8'h00;
  localparam logic [15:0] TEC_COUNT_RST   = 16'h0000;
  localparam logic [3:0]  TEC_MASK_RST    = 4'h0;

  // Source codes on the vector acknowledge
  localparam logic [1:0] TEC_VEC_X0 = 2'h0;
  localparam logic [1:0] TEC_VEC_T0 = 2'h1;
  localparam logic [1:0] TEC_VEC_X1 = 2'h2;
  localparam logic [1:0] TEC_VEC_T1 = 2'h3;

  // Timer operating modes, in mode-select order
  typedef enum logic [1:0] {
    tec_mode_prescale,
    tec_mode_wide,
    tec_mode_reload,
    tec_mode_split
  } tec_mode_t;
endpackage

// file: rtl/tec_sync2.sv
module tec_sync2 #(
  parameter int W = 2
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  // First stage, read only by the second
  logic [W-1:0] stage1;

  // Two-flop synchroniser
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= '1;
      o_sync <= '1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // tec_sync2

// file: rtl/tec_timer.sv
module tec_timer #(
  parameter bit SPLIT_OK = 1'b1
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_run,
  input  wire logic              i_run_high,
  input  wire tec_pkg::tec_mode_t i_mode,
  input  wire logic              i_load,
  input  wire logic [15:0]       i_load_data,
  output logic      [15:0]       o_count,
  output logic                   o_ovf,
  output logic                   o_ovf_high
);
  // Low and high count bytes
  logic [7:0] low;
  logic [7:0] high;
  logic [7:0] next_low;
  logic [7:0] next_high;

  assign o_count = {high, low};

  // Next count per mode
  always_comb begin
    next_low   = low;
    next_high  = high;
    o_ovf      = 1'b0;
    o_ovf_high = 1'b0;
    unique case (i_mode)
      // Low five bits act as prescaler for the high byte
      tec_pkg::tec_mode_prescale: if (i_run) begin
        {next_high, next_low[4:0]} = {high, low[4:0]} + 13'h1;
        o_ovf = &{high, low[4:0]};
      end
      tec_pkg::tec_mode_wide: if (i_run) begin
        {next_high, next_low} = {high, low} + 16'h1;
        o_ovf = &{high, low};
      end
      // High byte holds the start value
      tec_pkg::tec_mode_reload: if (i_run) begin
        next_low = (&low) ? high : low + 8'h1;
        o_ovf    = &low;
      end
      // Two bytes run apart; a timer without split holds
      tec_pkg::tec_mode_split: if (SPLIT_OK) begin
        if (i_run) begin
          next_low = low + 8'h1;
          o_ovf    = &low;
        end
        if (i_run_high) begin
          next_high  = high + 8'h1;
          o_ovf_high = &high;
        end
      end
    endcase
  end

  // Count registers; software load wins over counting
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {high, low} <= tec_pkg::TEC_COUNT_RST;
    end else if (i_load) begin
      {high, low} <= i_load_data;
    end else begin
      low  <= next_low;
      high <= next_high;
    end
  end
endmodule // tec_timer

// file: rtl/tec_timer_extint_control.sv
// Operation
// - Mode 0 prescaled eight-bit, mode 1 sixteen-bit
// - Mode 2 eight-bit with automatic reload
// - Mode 3 splits timer zero in two
// - Timer one overflow sets flag unless timer zero split, vector clears
// - Timer one counts while run set or while timer zero split, but holds in its own mode 3
// - Timer zero overflow sets flag, vector clears
// - Timer zero counts only while run set; split high byte on timer one's run
// - Pin one condition sets its detect flag
// - Pin one select: edge or low level
// - Pin zero condition sets its detect flag
// - Pin zero select: edge or low level
//
// Design decision made here: register access over APB.
module tec_timer_extint_control (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_irq_pin_zero,
  input  wire logic        i_ext_irq_pin_one,
  input  wire logic        i_vec_ack,
  input  wire logic [1:0]  i_vec_src,
  output logic             o_timer_zero_overflow_flag,
  output logic             o_timer_one_overflow_flag,
  output logic             o_ext_irq_zero_detected,
  output logic             o_ext_irq_one_detected,
  output logic             o_irq
);
  // Register state
  logic [7:0]         control;      // Flags, run bits, selects
  logic [7:0]         next_control;
  tec_pkg::tec_mode_t t0_mode;      // Timer zero mode
  tec_pkg::tec_mode_t t1_mode;      // Timer one mode
  logic [3:0]         status;       // Sticky events
  logic [3:0]         next_status;
  logic [3:0]         mask;         // Interrupt enables
  logic [3:0]         next_mask;
  logic [31:0]        rdata;        // Read mux
  logic               mapped;       // Address decodes

  // Bus phases
  logic setup;
  logic done;
  logic wr;
  logic rd;

  // Timer datapath
  logic [15:0] t0_count;
  logic [15:0] t1_count;
  logic        t0_ovf;
  logic        t0_ovf_high;
  logic        t1_ovf;
  logic        t0_split;
  logic        t0_load;
  logic        t1_load;
  logic        ovf0_set;
  logic        ovf1_set;

  // Pins and detection
  logic [1:0] pin_s;     // Synchronised pins
  logic [1:0] pin_prev;  // One cycle older
  logic [1:0] ext_set;   // Detect condition seen
  logic [3:0] events;

  // Vector acknowledge decode
  logic ack_t0;
  logic ack_t1;
  logic ack_x0;
  logic ack_x1;

  // Address compare, used by reads and writes
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Falling edge when selected, else low level
  function automatic logic ext_detect(input logic edge_sel,
                                      input logic prev,
                                      input logic cur);
    ext_detect = edge_sel ? (prev & !cur) : !cur;
  endfunction

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // APB phases; every access gets one wait-free access cycle
  assign setup = i_psel & !i_penable;
  assign done  = i_psel & i_penable & o_pready;
  assign wr    = done & i_pwrite;
  assign rd    = done & !i_pwrite;

  // Pins arrive from outside the clock domain
  tec_sync2 #(
    .W (2)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({i_ext_irq_pin_one, i_ext_irq_pin_zero}),
    .o_sync  (pin_s)
  );

  // Previous synchronised level for edge finding
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_prev <= 2'h3;
    end else begin
      pin_prev <= pin_s;
    end
  end

  // One detector per pin, select bit next below its flag
  for (genvar i = 0; i < 2; i++) begin : g_ext
    assign ext_set[i] = ext_detect(control[2*i],
                                   pin_prev[i], pin_s[i]);
  end

  // Acknowledge names one source for one cycle
  assign ack_t0 = i_vec_ack & (i_vec_src == tec_pkg::TEC_VEC_T0);
  assign ack_t1 = i_vec_ack & (i_vec_src == tec_pkg::TEC_VEC_T1);
  assign ack_x0 = i_vec_ack & (i_vec_src == tec_pkg::TEC_VEC_X0);
  assign ack_x1 = i_vec_ack & (i_vec_src == tec_pkg::TEC_VEC_X1);

  // Timers and their loads
  assign t0_split = (t0_mode == tec_pkg::tec_mode_split);
  assign t0_load  = wr & hit(i_paddr, tec_pkg::TEC_OFF_COUNT0);
  assign t1_load  = wr & hit(i_paddr, tec_pkg::TEC_OFF_COUNT1);

  tec_timer #(
    .SPLIT_OK (1'b1)
  ) u_timer0 (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_run       (control[tec_pkg::TEC_BIT_T0_RUN]),
    .i_run_high  (control[tec_pkg::TEC_BIT_T1_RUN]),
    .i_mode      (t0_mode),
    .i_load      (t0_load),
    .i_load_data (i_pwdata[15:0]),
    .o_count     (t0_count),
    .o_ovf       (t0_ovf),
    .o_ovf_high  (t0_ovf_high)
  );

  // While timer zero is split, timer one free-runs flagless outside its own mode 3, where it holds
  tec_timer #(
    .SPLIT_OK (1'b0)
  ) u_timer1 (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_run       (control[tec_pkg::TEC_BIT_T1_RUN] | t0_split),
    .i_run_high  (1'b0),
    .i_mode      (t1_mode),
    .i_load      (t1_load),
    .i_load_data (i_pwdata[15:0]),
    .o_count     (t1_count),
    .o_ovf       (t1_ovf),
    .o_ovf_high  ()
  );

  // Flag sources; split mode hands timer one's flag to the high byte
  assign ovf0_set = t0_ovf;
  assign ovf1_set = t0_split ? t0_ovf_high : t1_ovf;

  // Control next value: write, then acknowledges, then sets win
  always_comb begin
    next_control = control;
    if (wr && hit(i_paddr, tec_pkg::TEC_OFF_CONTROL)) begin
      next_control = i_pwdata[7:0];
    end
    if (ack_t1) begin
      next_control[tec_pkg::TEC_BIT_T1_FLAG] = 1'b0;
    end
    if (ack_t0) begin
      next_control[tec_pkg::TEC_BIT_T0_FLAG] = 1'b0;
    end
    // Edge flags also clear on entry; a low level re-sets at once
    if (ack_x1) begin
      next_control[tec_pkg::TEC_BIT_X1_FLAG] = 1'b0;
    end
    if (ack_x0) begin
      next_control[tec_pkg::TEC_BIT_X0_FLAG] = 1'b0;
    end
    if (ovf1_set) begin
      next_control[tec_pkg::TEC_BIT_T1_FLAG] = 1'b1;
    end
    if (ovf0_set) begin
      next_control[tec_pkg::TEC_BIT_T0_FLAG] = 1'b1;
    end
    if (ext_set[1]) begin
      next_control[tec_pkg::TEC_BIT_X1_FLAG] = 1'b1;
    end
    if (ext_set[0]) begin
      next_control[tec_pkg::TEC_BIT_X0_FLAG] = 1'b1;
    end
  end

  // Control register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control <= tec_pkg::TEC_CONTROL_RST;
    end else begin
      control <= next_control;
    end
  end

  // Mode register, one field per timer
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t0_mode <= tec_pkg::tec_mode_prescale;
      t1_mode <= tec_pkg::tec_mode_prescale;
    end else if (wr && hit(i_paddr, tec_pkg::TEC_OFF_MODE)) begin
      t0_mode <= tec_pkg::tec_mode_t'(
                   i_pwdata[tec_pkg::TEC_MODE0_LSB +: 2]);
      t1_mode <= tec_pkg::tec_mode_t'(
                   i_pwdata[tec_pkg::TEC_MODE1_LSB +: 2]);
    end
  end

  // Event vector in status layout
  assign events[tec_pkg::TEC_EV_T0] = ovf0_set;
  assign events[tec_pkg::TEC_EV_T1] = ovf1_set;
  assign events[tec_pkg::TEC_EV_X0] = ext_set[0];
  assign events[tec_pkg::TEC_EV_X1] = ext_set[1];

  // Read clears only the bits that read returned, so a new event
  // between setup and access is kept
  always_comb begin
    next_status = status;
    if (rd && hit(i_paddr, tec_pkg::TEC_OFF_STATUS)) begin
      next_status = status & ~o_prdata[3:0];
    end
    next_status = next_status | events;
    next_mask = mask;
    if (wr && hit(i_paddr, tec_pkg::TEC_OFF_MASK)) begin
      next_mask = i_pwdata[3:0];
    end
  end

  // Status, mask and the registered interrupt level
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status <= 4'h0;
      mask   <= tec_pkg::TEC_MASK_RST;
      o_irq  <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      o_irq  <= |(next_status & next_mask);
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(i_paddr, tec_pkg::TEC_OFF_CONTROL)) begin
      rdata[7:0] = control;
    end else if (hit(i_paddr, tec_pkg::TEC_OFF_MODE)) begin
      rdata[tec_pkg::TEC_MODE0_LSB +: 2] = t0_mode;
      rdata[tec_pkg::TEC_MODE1_LSB +: 2] = t1_mode;
    end else if (hit(i_paddr, tec_pkg::TEC_OFF_COUNT0)) begin
      rdata[15:0] = t0_count;
    end else if (hit(i_paddr, tec_pkg::TEC_OFF_COUNT1)) begin
      rdata[15:0] = t1_count;
    end else if (hit(i_paddr, tec_pkg::TEC_OFF_STATUS)) begin
      rdata[3:0] = status;
    end else if (hit(i_paddr, tec_pkg::TEC_OFF_MASK)) begin
      rdata[3:0] = mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // Answer built in setup, ready in the first access cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & !mapped;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  // Flags to the vectoring logic
  assign o_timer_zero_overflow_flag =
    control[tec_pkg::TEC_BIT_T0_FLAG];
  assign o_timer_one_overflow_flag =
    control[tec_pkg::TEC_BIT_T1_FLAG];
  assign o_ext_irq_zero_detected = control[tec_pkg::TEC_BIT_X0_FLAG];
  assign o_ext_irq_one_detected  = control[tec_pkg::TEC_BIT_X1_FLAG];

  AST_T1_FLAG_SET: assert property (
    ovf1_set |=> o_timer_one_overflow_flag)
    else $error("timer one overflow did not set its flag");
  AST_T1_FLAG_ACK: assert property (
    ack_t1 && !ovf1_set && !wr |=> !o_timer_one_overflow_flag)
    else $error("timer one flag survived vector entry");
  AST_T0_FLAG_SET: assert property (
    ovf0_set |=> o_timer_zero_overflow_flag)
    else $error("timer zero overflow did not set its flag");
  AST_T0_FLAG_ACK: assert property (
    ack_t0 && !ovf0_set && !wr |=> !o_timer_zero_overflow_flag)
    else $error("timer zero flag survived vector entry");
  AST_T1_STOP: assert property (
    !control[6] && !t0_split && !t1_load |=> $stable(t1_count))
    else $error("timer one moved while stopped");
  AST_T0_STOP: assert property (
    !control[4] && !t0_load |=> $stable(t0_count[7:0]))
    else $error("timer zero moved while stopped");
  AST_T0_WIDE: assert property (
    t0_mode == tec_pkg::tec_mode_wide && control[4] && !t0_load
    |=> t0_count == $past(t0_count) + 16'h1)
    else $error("sixteen-bit count did not step");
  AST_T0_PRESCALE: assert property (
    t0_mode == tec_pkg::tec_mode_prescale && control[4] &&
    !t0_load && t0_count[4:0] == 5'h1f
    |=> t0_count[15:8] == $past(t0_count[15:8]) + 8'h1 &&
        t0_count[4:0] == 5'h00)
    else $error("prescaler carry missing");
  AST_T0_RELOAD: assert property (
    t0_mode == tec_pkg::tec_mode_reload && control[4] &&
    !t0_load && t0_count[7:0] == 8'hff
    |=> t0_count[7:0] == $past(t0_count[15:8]) && o_timer_zero_overflow_flag)
    else $error("reload did not restore start value");
  AST_T0_SPLIT: assert property (
    t0_split && control[6] && !t0_load && t0_count[15:8] == 8'hff
    |=> t0_count[15:8] == 8'h00 && o_timer_one_overflow_flag)
    else $error("split high byte did not wrap into flag");
  AST_X1_EDGE: assert property (
    control[2] && pin_s[1] ##1 !pin_s[1] |=> o_ext_irq_one_detected)
    else $error("pin one falling edge missed");
  AST_X0_LEVEL: assert property (
    !control[0] && !pin_s[0] |=> o_ext_irq_zero_detected)
    else $error("pin zero low level missed");
  AST_IRQ_LEVEL: assert property (
    o_irq == |(status & mask))
    else $error("interrupt disagrees with status and mask");
  AST_APB_READY: assert property (
    setup |=> o_pready ##1 !o_pready || setup)
    else $error("access phase not answered in one cycle");

  COV_SPLIT_FLAG: cover property (t0_split && ovf1_set);
  COV_EDGE: cover property (control[2] && ext_set[1]);
  COV_RELOAD: cover property (
    t0_mode == tec_pkg::tec_mode_reload && ovf0_set);
  COV_STATUS_CLEAR: cover property (
    rd && hit(i_paddr, tec_pkg::TEC_OFF_STATUS) && |status);
endmodule // tec_timer_extint_control

// file: bench/tec_core_model.sv
module tec_core_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_enable,  // Service pending flags
  input  wire logic [2:0] i_delay,   // Cycles before vectoring
  input  wire logic [3:0] i_flags,   // Timer 0, timer 1, pin 0, pin 1
  output logic            o_vec_ack,
  output logic      [1:0] o_vec_src
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] wait_cnt;  // Latency before the acknowledge

  // One-cycle acknowledge, then a gap while the flag drops
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_vec_ack <= 1'b0;
      o_vec_src <= 2'h0;
      wait_cnt  <= 3'h0;
    end else if (i_enable && (|i_flags) && !o_vec_ack) begin
      if (wait_cnt == i_delay) begin
        o_vec_ack <= 1'b1;
        wait_cnt  <= 3'h0;
        o_vec_src <= i_flags[0] ? tec_pkg::TEC_VEC_T0 :
                     i_flags[1] ? tec_pkg::TEC_VEC_T1 :
                     i_flags[2] ? tec_pkg::TEC_VEC_X0 :
                                  tec_pkg::TEC_VEC_X1;
      end else begin
        // Source is meaningless here, so keep it moving
        o_vec_src <= ~o_vec_src;
        wait_cnt  <= wait_cnt + 3'h1;
      end
    end else begin
      o_vec_ack <= 1'b0;
      o_vec_src <= ~o_vec_src;
      wait_cnt  <= 3'h0;
    end
  end
endmodule // tec_core_model

// file: bench/tb.sv
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} tec_exp_t;

  localparam logic [11:0] CTL = tec_pkg::TEC_OFF_CONTROL;
  localparam logic [11:0] MOD = tec_pkg::TEC_OFF_MODE;
  localparam logic [11:0] CN0 = tec_pkg::TEC_OFF_COUNT0;
  localparam logic [11:0] STA = tec_pkg::TEC_OFF_STATUS;
  localparam logic [11:0] MSK = tec_pkg::TEC_OFF_MASK;
  localparam logic [31:0] ALL = 32'hffffffff;

  logic        i_clock, i_rst_b, psel, penable, pwrite, en;
  logic [11:0] paddr, ca;
  logic [31:0] pwdata, o_prdata, seed;
  logic        o_pready, o_pslverr, ack, o_irq;
  logic [1:0]  pin, src;
  logic [2:0]  dly;
  logic [7:0]  run, flg, eb, fb;
  logic        f_t0, f_t1, f_x0, f_x1;  // Flag outputs
  int          failures, n_tests;
  tec_exp_t    q[$];  // Expected answers, oldest first
  tec_exp_t    e;

  tec_timer_extint_control tec_timer_extint_control_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_ext_irq_pin_zero(pin[0]),
    .i_ext_irq_pin_one(pin[1]), .i_vec_ack(ack), .i_vec_src(src),
    .o_timer_zero_overflow_flag(f_t0), .o_timer_one_overflow_flag(f_t1),
    .o_ext_irq_zero_detected(f_x0), .o_ext_irq_one_detected(f_x1),
    .o_irq(o_irq));

  tec_core_model tec_core_model_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(en),
    .i_delay(dly), .i_flags({f_x1, f_x0, f_t1, f_t0}),
    .o_vec_ack(ack), .o_vec_src(src));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One APB transfer; request held until pready seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, input logic [31:0] ex,
                      input logic [31:0] m, input logic er);
    q.push_back('{ex, m, er});
    @(posedge i_clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                    input logic [31:0] m);
    xfer(1'b0, a, 32'h0, ex, m, 1'b0);
  endtask

  task automatic results();
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Free-running 10 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Answer checker, takes the answer at the completing edge
  always @(posedge i_clock) begin
    if (psel && penable && o_pready === 1'b1) begin
      if (q.size() == 0) begin
        `CHK("queue", 1'b1, 1'b0)
      end else begin
        e = q.pop_front();
        `CHK("prdata", e.d & e.m, o_prdata & e.m)
        `CHK("pslverr", e.e, o_pslverr)
      end
    end
  end

  // Hang guard, far beyond the expected run
  initial begin
    repeat (5000) @(posedge i_clock);
    failures++;
    results();
  end

  initial begin
    i_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin = 2'h3;
    en = 1'b0;
    dly = 3'h0;
    seed = 32'h8eed81d0;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    // All registers come up zero
    for (int k = 0; k < 6; k++) rd(CTL + 12'(4 * k), 32'h0, ALL);
    seed = lfsr(seed);
    xfer(1'b1, 12'h0a0, seed, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, 12'h0a0, 32'h0, 32'h0, ALL, 1'b1);
    // Wide mode overflow, vector clear, then stop and hold
    for (int i = 0; i < 2; i++) begin
      run = 8'h10 << (2 * i);
      flg = 8'h20 << (2 * i);
      ca  = CN0 + 12'(4 * i);
      wr(ca, 32'hfff0);
      wr(MOD, 32'h1 << (4 * i));
      wr(CTL, {24'h0, run});
      repeat (30) @(posedge i_clock);
      rd(CTL, {24'h0, run | flg}, 32'hf0);
      `CHK("flag", 1'b1, i ? f_t1 : f_t0)
      dly <= seed[2:0];
      en  <= 1'b1;
      repeat (20) @(posedge i_clock);
      rd(CTL, {24'h0, run}, 32'hf0);
      `CHK("flag", 1'b0, i ? f_t1 : f_t0)
      en <= 1'b0;
      wr(CTL, 32'h0);
      seed = lfsr(seed);
      wr(ca, {16'h0, seed[15:0]});
      repeat (10) @(posedge i_clock);
      rd(ca, {16'h0, seed[15:0]}, ALL);
    end
    // Prescale carry, upper low bits held
    wr(MOD, 32'h0);
    wr(CN0, 32'h00ff);
    wr(CTL, 32'h10);
    wr(CTL, 32'h0);
    rd(CN0, 32'h01e0, 32'hffe0);
    // Auto reload keeps the high byte
    wr(MOD, 32'h2);
    wr(CN0, 32'h80f8);
    wr(CTL, 32'h10);
    repeat (20) @(posedge i_clock);
    rd(CTL, 32'h30, 32'hf0);
    wr(CTL, 32'h0);
    rd(CN0, 32'h8080, 32'hff80);
    // Split: high byte on timer one's run and flag
    wr(MOD, 32'h3);
    wr(CN0, 32'hf012);
    wr(CTL, 32'h40);
    repeat (30) @(posedge i_clock);
    rd(CTL, 32'hc0, 32'hf0);
    `CHK("flag", 1'b1, f_t1)
    wr(CTL, 32'h0);
    rd(CN0, 32'h0012, 32'h00ff);
    wr(MOD, 32'h0);
    // Both pins, edge then level detection
    for (int p = 0; p < 2; p++) begin
      eb = 8'h1 << (2 * p);
      fb = 8'h2 << (2 * p);
      wr(CTL, {24'h0, eb});
      pin[p] <= 1'b0;
      repeat (8) @(posedge i_clock);
      `CHK("detect", 1'b1, p ? f_x1 : f_x0)
      rd(CTL, {24'h0, eb | fb}, ALL);
      // Core enters the pin's routine, which clears its flag
      en <= 1'b1;
      repeat (12) @(posedge i_clock);
      en <= 1'b0;
      repeat (8) @(posedge i_clock);
      rd(CTL, {24'h0, eb}, ALL);
      pin[p] <= 1'b1;
      wr(CTL, 32'h0);
      pin[p] <= 1'b0;
      repeat (8) @(posedge i_clock);
      wr(CTL, 32'h0);
      repeat (8) @(posedge i_clock);
      rd(CTL, {24'h0, fb}, ALL);
      pin[p] <= 1'b1;
      repeat (8) @(posedge i_clock);
      wr(CTL, 32'h0);
      repeat (4) @(posedge i_clock);
      rd(CTL, 32'h0, ALL);
    end
    // Interrupt: unmasked, cleared by read, then masked
    rd(STA, 32'h0, 32'h0);
    wr(MSK, 32'h4);
    rd(MSK, 32'h4, ALL);
    wr(CTL, 32'h1);
    pin[0] <= 1'b0;
    repeat (8) @(posedge i_clock);
    `CHK("irq", 1'b1, o_irq)
    rd(STA, 32'h4, 32'h4);
    repeat (2) @(posedge i_clock);
    `CHK("irq", 1'b0, o_irq)
    rd(STA, 32'h0, 32'h4);
    pin[0] <= 1'b1;
    wr(MSK, 32'h0);
    pin[0] <= 1'b0;
    repeat (8) @(posedge i_clock);
    `CHK("irq", 1'b0, o_irq)
    rd(STA, 32'h4, 32'h4);
    pin[0] <= 1'b1;
    repeat (4) @(posedge i_clock);
    results();
  end
endmodule // tb
